// ---- src/bidir_message_framer.sv ----
// Framing engine: buffer memory on one side, a byte stream to a serial link on the other.
// Assumes a byte-wide transmitter and receiver on ref_clk_in and a controller on the same clock.
`timescale 1ns/1ns
`include "bmf_defs.svh"

// How it works
// - Control codes added on send, hidden on receive.
// - Length counts words or bytes per unit select.
// - Send count sent unchanged, low byte first.
// - Valid received length stored, first byte low.
// - Data sent unchanged from lowest send address.
// - Valid received data stored in ascending order.
// - Sum is low 16 bits of length plus data.
// - Sum appended only while the sum switch is on.
// - Received sum verified, never shown to software.
// - Without sum, surplus bytes dropped until ENQ.
// - Own NAK code also written to receive result.
// - Received partner error code kept in transmit result.
// - ASCII mode converts length, data and error code.
// - ASCII length is four hex characters, low first.
// - ASCII words sent as four characters; pairs packed.
// - ASCII error code four characters, low byte first.
// - ASCII sum: binary on send, characters on receive.
// - Escape byte inserted before transparent or escape byte in length, data and error code.
// - Received escape in length, data or error code dropped, next byte taken literally.
// - Escaping after conversion, unescaping before conversion.
// - Escape bytes excluded from length and sum.
module bidir_message_framer
   import bmf_pkg::*;
#(
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic srst_in,
   // Buffer memory port
   input wire bm_req_s bm_req_in,
   output logic [15:0] bm_rdata_out,
   // Controller signals
   input wire logic send_req_in,
   input wire logic sum_check_switch_in,
   output logic tx_done_out,
   output logic tx_fail_out,
   output logic rx_done_out,
   output logic rx_fail_out,
   output logic busy_out,
   // Serial byte stream
   input wire logic [7:0] rx_byte_in,
   input wire logic rx_valid_in,
   output logic [7:0] tx_byte_out,
   output logic tx_valid_out,
   input wire logic tx_ready_in
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [16:0] CAP = 17'(2 * DEPTH);

   if (DEPTH < 2 || DEPTH > 1024 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("DEPTH must be a power of two from 2 to 1024.");
   end

   function automatic logic [7:0] to_asc(input logic [3:0] n);
      return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction

   function automatic logic [4:0] from_asc(input logic [7:0] c);
      if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
      if (c >= 8'h41 && c <= 8'h46) return {1'b1, c[3:0] + 4'h9};
      return 5'h00;
   endfunction

   logic [15:0] unit_r, txesc_r, rxesc_r, ascii_r, tres_r, rres_r, scount_r, rcount_r;
   logic [15:0] tx_mem [DEPTH];
   logic [15:0] rx_mem [DEPTH];
   state_e st_r, after_tx;
   logic [15:0] idx_r, nb_r, sum_r, err_r, fend, nak_code, rd_nxt, tw;
   logic [7:0] lo_r, cur_b, ch, out_b, c, bin_b, tx_byte_r;
   logic [3:0] hold_r;
   logic [4:0] dec;
   logic [16:0] tx_req, rx_nb;
   logic [15:0] tx_nb;
   logic [11:0] ra_tx, ra_rx;
   logic nib_r, esc_sent_r, rx_esc_r, rnib_r, tx_valid_r;
   logic tx_done_r, tx_fail_r, rx_done_r, rx_fail_r;
   logic byte_mode, ascii_on, field, emitting, need_esc, fire, step, last;
   logic rx_field, drop_esc, c_ok, hex_bad, bin_ok, nak_now;
   esc_cfg_s txe, rxe;

   assign byte_mode = unit_r[`BMF_UNIT_BYTE_BIT];
   assign ascii_on = ascii_r[`BMF_ASCII_ON_BIT];
   assign txe = esc_cfg_s'(txesc_r);
   assign rxe = esc_cfg_s'(rxesc_r);
   // The send amount is clamped to the area so a large count cannot read past it.
   assign tx_req = byte_mode ? {1'b0, scount_r} : {scount_r, 1'b0};
   assign tx_nb = (tx_req > CAP) ? CAP[15:0] : tx_req[15:0];
   assign tw = tx_mem[idx_r[AW:1]];

   // Transmit side: pick the binary byte of the field being sent.
   always_comb begin
      unique case (st_r)
         ST_TX_ENQ: cur_b = `BMF_ENQ;
         ST_TX_LEN: cur_b = idx_r[0] ? scount_r[15:8] : scount_r[7:0];
         ST_TX_DATA: cur_b = idx_r[0] ? tw[15:8] : tw[7:0];
         ST_TX_SUM: cur_b = idx_r[0] ? sum_r[15:8] : sum_r[7:0];
         ST_RP_ACK: cur_b = `BMF_ACK;
         ST_RP_NAK: cur_b = `BMF_NAK;
         ST_RP_ERRC: cur_b = idx_r[0] ? err_r[15:8] : err_r[7:0];
         default: cur_b = 8'h00;
      endcase
   end

   always_comb begin
      unique case (st_r)
         ST_TX_DATA: fend = tx_nb;
         ST_RX_DATA: fend = nb_r;
         ST_TX_ENQ, ST_RP_ACK, ST_RP_NAK: fend = 16'h0001;
         default: fend = 16'h0002;
      endcase
   end

   always_comb begin
      unique case (st_r)
         ST_TX_ENQ: after_tx = ST_TX_LEN;
         ST_TX_LEN: after_tx = (tx_nb != 16'h0000) ? ST_TX_DATA : (sum_check_switch_in ? ST_TX_SUM : ST_TX_WAIT);
         ST_TX_DATA: after_tx = sum_check_switch_in ? ST_TX_SUM : ST_TX_WAIT;
         ST_TX_SUM: after_tx = ST_TX_WAIT;
         ST_RP_NAK: after_tx = ST_RP_ERRC;
         default: after_tx = ST_IDLE;
      endcase
   end

   assign field = (st_r == ST_TX_LEN) || (st_r == ST_TX_DATA) || (st_r == ST_RP_ERRC);
   assign emitting = field || (st_r == ST_TX_ENQ) || (st_r == ST_TX_SUM) || (st_r == ST_RP_ACK) ||
                     (st_r == ST_RP_NAK);
   // High nibble first keeps the low byte's characters in reading order.
   assign ch = (field && ascii_on) ? to_asc(nib_r ? cur_b[3:0] : cur_b[7:4]) : cur_b;
   // Escaping looks at the converted character, so it runs after conversion.
   assign need_esc = field && (txe.add != 8'h00) && !esc_sent_r && (ch == txe.trans || ch == txe.add);
   assign out_b = need_esc ? txe.add : ch;
   assign fire = emitting && (!tx_valid_r || tx_ready_in);
   assign step = fire && !need_esc && (!field || !ascii_on || nib_r);
   assign last = (idx_r == fend - 16'h0001);

   always_ff @(posedge ref_clk_in) begin : p_txout
      if (srst_in) begin
         tx_byte_r <= 8'h00;
         tx_valid_r <= 1'b0;
      end else if (fire) begin
         tx_byte_r <= out_b;
         tx_valid_r <= 1'b1;
      end else if (tx_ready_in) begin
         tx_valid_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in) begin : p_txchar
      if (srst_in || !field) begin
         nib_r <= 1'b0;
         esc_sent_r <= 1'b0;
      end else if (fire) begin
         esc_sent_r <= need_esc;
         if (!need_esc && ascii_on) nib_r <= ~nib_r;
      end
   end

   // Receive side: unescape first, then pack character pairs.
   assign rx_field = (st_r == ST_RX_LEN) || (st_r == ST_RX_DATA) || (st_r == ST_TX_ERRC);
   assign drop_esc = rx_valid_in && rx_field && (rxe.add != 8'h00) && !rx_esc_r && rx_byte_in == rxe.add;
   assign c_ok = rx_valid_in && !drop_esc;
   assign c = rx_byte_in;
   assign dec = from_asc(c);
   assign hex_bad = c_ok && rx_field && ascii_on && !dec[4];
   assign bin_b = ascii_on ? {hold_r, dec[3:0]} : c;
   assign bin_ok = c_ok && rx_field && (!ascii_on || rnib_r) && !hex_bad;
   assign rx_nb = byte_mode ? {1'b0, bin_b, lo_r} : {bin_b, lo_r, 1'b0};

   always_ff @(posedge ref_clk_in) begin : p_rxchar
      if (srst_in || !rx_field) begin
         rx_esc_r <= 1'b0;
         rnib_r <= 1'b0;
         hold_r <= 4'h0;
      end else if (rx_valid_in) begin
         rx_esc_r <= drop_esc;
         if (c_ok && ascii_on) begin
            rnib_r <= ~rnib_r;
            hold_r <= dec[3:0];
         end
      end
   end

   always_comb begin
      nak_now = 1'b0;
      nak_code = `BMF_ERR_HEX;
      if (hex_bad && st_r != ST_TX_ERRC) begin
         nak_now = 1'b1;
      end else if (st_r == ST_RX_LEN && bin_ok && idx_r[0] && rx_nb > CAP) begin
         nak_now = 1'b1;
         nak_code = `BMF_ERR_LEN;
      end else if (st_r == ST_RX_SUM && rx_valid_in && idx_r[0] && {rx_byte_in, lo_r} != sum_r) begin
         nak_now = 1'b1;
         nak_code = `BMF_ERR_SUM;
      end
   end

   // Sum over binary bytes on send and over received characters on receive.
   always_ff @(posedge ref_clk_in) begin : p_sum
      if (srst_in || st_r == ST_IDLE) begin
         sum_r <= 16'h0000;
      end else if (step && (st_r == ST_TX_LEN || st_r == ST_TX_DATA)) begin
         sum_r <= sum_r + {8'h00, cur_b};
      end else if (c_ok && (st_r == ST_RX_LEN || st_r == ST_RX_DATA)) begin
         sum_r <= sum_r + {8'h00, c};
      end
   end

   always_ff @(posedge ref_clk_in) begin : p_fsm
      if (srst_in) begin
         st_r <= ST_IDLE;
         idx_r <= 16'h0000;
         lo_r <= 8'h00;
         nb_r <= 16'h0000;
         err_r <= `BMF_RST_RESULT;
         rcount_r <= `BMF_RST_COUNT;
         tres_r <= `BMF_RST_RESULT;
         rres_r <= `BMF_RST_RESULT;
         tx_done_r <= 1'b0;
         tx_fail_r <= 1'b0;
         rx_done_r <= 1'b0;
         rx_fail_r <= 1'b0;
      end else begin
         tx_done_r <= 1'b0;
         tx_fail_r <= 1'b0;
         rx_done_r <= 1'b0;
         rx_fail_r <= 1'b0;
         if (nak_now) begin
            st_r <= ST_RP_NAK;
            idx_r <= 16'h0000;
            err_r <= nak_code;
            rres_r <= nak_code;
         end else begin
            unique case (st_r)
               ST_IDLE: begin
                  idx_r <= 16'h0000;
                  // Anything other than ENQ is surplus and is dropped here.
                  if (rx_valid_in && rx_byte_in == `BMF_ENQ) st_r <= ST_RX_LEN;
                  else if (send_req_in) st_r <= ST_TX_ENQ;
               end
               ST_TX_ENQ, ST_TX_LEN, ST_TX_DATA, ST_TX_SUM, ST_RP_ACK, ST_RP_NAK, ST_RP_ERRC: begin
                  if (step && !last) begin
                     idx_r <= idx_r + 16'h0001;
                  end else if (step) begin
                     idx_r <= 16'h0000;
                     st_r <= after_tx;
                     if (st_r == ST_RP_ACK) begin
                        rx_done_r <= 1'b1;
                        rres_r <= `BMF_RST_RESULT;
                     end
                     if (st_r == ST_RP_ERRC) rx_fail_r <= 1'b1;
                  end
               end
               ST_TX_WAIT: begin
                  if (rx_valid_in && rx_byte_in == `BMF_ACK) begin
                     st_r <= ST_IDLE;
                     tres_r <= `BMF_RST_RESULT;
                     tx_done_r <= 1'b1;
                  end else if (rx_valid_in && rx_byte_in == `BMF_NAK) begin
                     st_r <= ST_TX_ERRC;
                     idx_r <= 16'h0000;
                  end
               end
               ST_TX_ERRC: begin
                  if (hex_bad) begin
                     st_r <= ST_IDLE;
                     tres_r <= `BMF_ERR_HEX;
                     tx_fail_r <= 1'b1;
                  end else if (bin_ok && !idx_r[0]) begin
                     lo_r <= bin_b;
                     idx_r <= 16'h0001;
                  end else if (bin_ok) begin
                     st_r <= ST_IDLE;
                     tres_r <= {bin_b, lo_r};
                     tx_fail_r <= 1'b1;
                  end
               end
               ST_RX_LEN: begin
                  if (bin_ok && !idx_r[0]) begin
                     lo_r <= bin_b;
                     idx_r <= 16'h0001;
                  end else if (bin_ok) begin
                     rcount_r <= {bin_b, lo_r};
                     nb_r <= rx_nb[15:0];
                     idx_r <= 16'h0000;
                     if (rx_nb != 17'h0_0000) st_r <= ST_RX_DATA;
                     else st_r <= sum_check_switch_in ? ST_RX_SUM : ST_RP_ACK;
                  end
               end
               ST_RX_DATA: begin
                  if (bin_ok && !last) begin
                     idx_r <= idx_r + 16'h0001;
                  end else if (bin_ok) begin
                     idx_r <= 16'h0000;
                     st_r <= sum_check_switch_in ? ST_RX_SUM : ST_RP_ACK;
                  end
               end
               ST_RX_SUM: begin
                  if (rx_valid_in && !idx_r[0]) begin
                     lo_r <= rx_byte_in;
                     idx_r <= 16'h0001;
                  end else if (rx_valid_in) begin
                     st_r <= ST_RP_ACK;
                     idx_r <= 16'h0000;
                  end
               end
            endcase
         end
      end
   end

   // An odd byte count leaves the high byte of the last word at zero.
   always_ff @(posedge ref_clk_in) begin : p_rxmem
      if (bin_ok && st_r == ST_RX_DATA) begin
         if (!idx_r[0]) rx_mem[idx_r[AW:1]] <= {8'h00, bin_b};
         else rx_mem[idx_r[AW:1]][15:8] <= bin_b;
      end
   end

   // Buffer memory writes by the controller.
   always_ff @(posedge ref_clk_in) begin : p_cfg
      if (srst_in) begin
         unit_r <= `BMF_RST_UNIT;
         txesc_r <= `BMF_RST_ESC;
         rxesc_r <= `BMF_RST_ESC;
         ascii_r <= `BMF_RST_ASCII;
         scount_r <= `BMF_RST_COUNT;
      end else if (bm_req_in.wr) begin
         if (bm_req_in.addr == `BMF_ADDR_UNIT) unit_r <= bm_req_in.wdata;
         if (bm_req_in.addr == `BMF_ADDR_TXESC) txesc_r <= bm_req_in.wdata;
         if (bm_req_in.addr == `BMF_ADDR_RXESC) rxesc_r <= bm_req_in.wdata;
         if (bm_req_in.addr == `BMF_ADDR_ASCII) ascii_r <= bm_req_in.wdata;
         if (bm_req_in.addr == `BMF_ADDR_TXCNT) scount_r <= bm_req_in.wdata;
      end
   end

   for (genvar g = 0; g < DEPTH; g++) begin : g_txw
      always_ff @(posedge ref_clk_in) begin
         if (bm_req_in.wr && bm_req_in.addr == `BMF_ADDR_TXDAT + 12'(g)) tx_mem[g] <= bm_req_in.wdata;
      end
   end

   assign ra_tx = bm_req_in.addr - `BMF_ADDR_TXDAT;
   assign ra_rx = bm_req_in.addr - `BMF_ADDR_RXDAT;

   // Control codes and the received sum have no readable location.
   always_comb begin
      rd_nxt = 16'h0000;
      if (bm_req_in.addr == `BMF_ADDR_UNIT) rd_nxt = unit_r;
      else if (bm_req_in.addr == `BMF_ADDR_TXESC) rd_nxt = txesc_r;
      else if (bm_req_in.addr == `BMF_ADDR_RXESC) rd_nxt = rxesc_r;
      else if (bm_req_in.addr == `BMF_ADDR_ASCII) rd_nxt = ascii_r;
      else if (bm_req_in.addr == `BMF_ADDR_TXRES) rd_nxt = tres_r;
      else if (bm_req_in.addr == `BMF_ADDR_RXRES) rd_nxt = rres_r;
      else if (bm_req_in.addr == `BMF_ADDR_TXCNT) rd_nxt = scount_r;
      else if (bm_req_in.addr == `BMF_ADDR_RXCNT) rd_nxt = rcount_r;
      else if (ra_tx < 12'(DEPTH)) rd_nxt = tx_mem[ra_tx[AW-1:0]];
      else if (ra_rx < 12'(DEPTH)) rd_nxt = rx_mem[ra_rx[AW-1:0]];
   end

   always_ff @(posedge ref_clk_in) begin : p_rd
      if (srst_in) bm_rdata_out <= 16'h0000;
      else bm_rdata_out <= rd_nxt;
   end

   assign tx_byte_out = tx_byte_r;
   assign tx_valid_out = tx_valid_r;
   assign tx_done_out = tx_done_r;
   assign tx_fail_out = tx_fail_r;
   assign rx_done_out = rx_done_r;
   assign rx_fail_out = rx_fail_r;
   assign busy_out = (st_r != ST_IDLE);

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);

   sequence s_send_enq;
      st_r == ST_TX_ENQ && fire;
   endsequence
   sequence s_nak_sent;
      st_r == ST_RP_NAK && step ##1 st_r == ST_RP_ERRC;
   endsequence

   property p_enq_first;
      s_send_enq |=> tx_valid_out && tx_byte_out == `BMF_ENQ ##0 st_r == ST_TX_LEN;
   endproperty
   a_enq_first: assert property (p_enq_first) else $error("ENQ not sent first.");

   property p_len_low;
      st_r == ST_TX_LEN && idx_r == 16'h0000 && step && !ascii_on |=> tx_byte_out == $past(scount_r[7:0]);
   endproperty
   a_len_low: assert property (p_len_low) else $error("Length low byte wrong.");

   property p_rx_len;
      st_r == ST_RX_LEN && bin_ok && idx_r[0] && !nak_now |=> rcount_r == {$past(bin_b), $past(lo_r)};
   endproperty
   a_rx_len: assert property (p_rx_len) else $error("Received length not stored.");

   property p_nak_code;
      s_nak_sent |-> rres_r == err_r && (err_r == `BMF_ERR_HEX || err_r == `BMF_ERR_LEN || err_r == `BMF_ERR_SUM);
   endproperty
   a_nak_code: assert property (p_nak_code) else $error("NAK code not in receive result.");

   property p_sum_bad;
      st_r == ST_RX_SUM && rx_valid_in && idx_r[0] && {rx_byte_in, lo_r} != sum_r |=> st_r == ST_RP_NAK;
   endproperty
   a_sum_bad: assert property (p_sum_bad) else $error("Bad sum accepted.");

   property p_no_sum;
      st_r == ST_RX_DATA && bin_ok && last && !sum_check_switch_in && !nak_now |=> st_r == ST_RP_ACK;
   endproperty
   a_no_sum: assert property (p_no_sum) else $error("Sum awaited while switch is off.");

   property p_esc;
      fire && need_esc |=> tx_valid_out && tx_byte_out == txe.add && esc_sent_r;
   endproperty
   a_esc: assert property (p_esc) else $error("Escape byte not inserted.");

   property p_tres;
      st_r == ST_TX_ERRC && bin_ok && idx_r[0] |=> tres_r == {$past(bin_b), $past(lo_r)} && tx_fail_out;
   endproperty
   a_tres: assert property (p_tres) else $error("Partner error code not kept.");

   property p_ascii_char;
      fire && field && ascii_on && !need_esc |=> (tx_byte_out inside {[8'h30:8'h39], [8'h41:8'h46]});
   endproperty
   a_ascii_char: assert property (p_ascii_char) else $error("Non-hex character sent.");

endmodule // bidir_message_framer

// ---- src/bmf_defs.svh ----
// Constants of the bidirectional message framer: buffer-memory word addresses,
// reset values, control codes, field positions and the framer's own error codes.
// Assumes the includer works on 12-bit word addresses and 16-bit data.
`ifndef BMF_DEFS_SVH
`define BMF_DEFS_SVH

`define BMF_ADDR_UNIT 12'h096
`define BMF_ADDR_TXESC 12'h11F
`define BMF_ADDR_RXESC 12'h120
`define BMF_ADDR_ASCII 12'h121
`define BMF_ADDR_TXRES 12'h257
`define BMF_ADDR_RXRES 12'h258
`define BMF_ADDR_TXCNT 12'h400
`define BMF_ADDR_TXDAT 12'h401
`define BMF_ADDR_RXCNT 12'h600
`define BMF_ADDR_RXDAT 12'h601

`define BMF_RST_UNIT 16'h0000
`define BMF_RST_ESC 16'h0000
`define BMF_RST_ASCII 16'h0000
`define BMF_RST_RESULT 16'h0000
`define BMF_RST_COUNT 16'h0000

`define BMF_UNIT_BYTE_BIT 0
`define BMF_ASCII_ON_BIT 0

`define BMF_ENQ 8'h05
`define BMF_ACK 8'h06
`define BMF_NAK 8'h15

`define BMF_ERR_HEX 16'h7101
`define BMF_ERR_LEN 16'h7102
`define BMF_ERR_SUM 16'h7103

`endif

// ---- src/bmf_pkg.sv ----
// Types shared by the bidirectional message framer.
// Assumes nothing of its surroundings.
package bmf_pkg;

   typedef enum logic [3:0] {
      ST_IDLE, ST_TX_ENQ, ST_TX_LEN, ST_TX_DATA, ST_TX_SUM, ST_TX_WAIT, ST_TX_ERRC,
      ST_RX_LEN, ST_RX_DATA, ST_RX_SUM, ST_RP_ACK, ST_RP_NAK, ST_RP_ERRC
   } state_e;

   typedef struct packed {
      logic wr;
      logic [11:0] addr;
      logic [15:0] wdata;
   } bm_req_s;

   typedef struct packed {
      logic [7:0] add;
      logic [7:0] trans;
   } esc_cfg_s;

endpackage

// ---- verification/serial_peer_model.sv ----
// Far-side serial device: collects the framer's bytes and sends framed bytes back.
// Assumes one clock shared with the framer and byte-wide handshakes on it.
`timescale 1ns/1ns
module serial_peer_model (
   // Clock
   input wire logic clk_in,
   // Bytes from the framer
   input wire logic [7:0] tx_byte_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   // Bytes to the framer
   output logic [7:0] rx_byte_out,
   output logic rx_valid_out
);
   logic slow;
   logic [7:0] got[$];
   int unsigned cyc;

   initial begin
      slow = 1'b0;
      cyc = 0;
      tx_ready_out = 1'b1;
      rx_byte_out = 8'h00;
      rx_valid_out = 1'b0;
   end

   // A slow peer drops ready for two cycles out of four to stall the framer.
   always @(posedge clk_in) begin
      if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1) begin
         got.push_back(tx_byte_in);
      end
      cyc++;
      #1 tx_ready_out = !slow || cyc[1];
   end

   // One byte as a one-cycle pulse; the line shows the inverse once released.
   task automatic send(input logic [7:0] b);
      @(posedge clk_in);
      #1 rx_byte_out = b;
      rx_valid_out = 1'b1;
      @(posedge clk_in);
      #1 rx_valid_out = 1'b0;
      rx_byte_out = ~b;
   endtask
endmodule // serial_peer_model

// ---- verification/tb_bidir_message_framer.sv ----
// Self-checking bench for the message framer with a far-side peer model.
// Assumes the framer's registered outputs and the buffer map of the defines header.
`timescale 1ns/1ns
`include "bmf_defs.svh"
module tb_bidir_message_framer;
   import bmf_pkg::*;
   logic ref_clk_in, srst_in, send_req_in, sum_check_switch_in, tx_ready_in, rx_valid_in;
   logic tx_done_out, tx_fail_out, rx_done_out, rx_fail_out, busy_out, tx_valid_out;
   logic [7:0] rx_byte_in, tx_byte_out;
   logic [15:0] bm_rdata_out, rv;
   bm_req_s bm_req_in;
   int err_count, tests_run, n_txd, n_txf, n_rxd, n_rxf;
   logic [7:0] exp_q[$];
   logic [7:0] rep_q[$];

   bidir_message_framer #(.DEPTH(8)) bidir_message_framer_i (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
      .bm_req_in(bm_req_in), .bm_rdata_out(bm_rdata_out), .send_req_in(send_req_in),
      .sum_check_switch_in(sum_check_switch_in), .tx_done_out(tx_done_out), .tx_fail_out(tx_fail_out),
      .rx_done_out(rx_done_out), .rx_fail_out(rx_fail_out), .busy_out(busy_out), .rx_byte_in(rx_byte_in),
      .rx_valid_in(rx_valid_in), .tx_byte_out(tx_byte_out), .tx_valid_out(tx_valid_out),
      .tx_ready_in(tx_ready_in));
   serial_peer_model serial_peer_model_i (.clk_in(ref_clk_in), .tx_byte_in(tx_byte_out),
      .tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready_in), .rx_byte_out(rx_byte_in),
      .rx_valid_out(rx_valid_in));

   initial begin
      ref_clk_in = 1'b0;
      forever #4 ref_clk_in = ~ref_clk_in;
   end

   always @(posedge ref_clk_in) begin
      if (tx_done_out === 1'b1) n_txd++;
      if (tx_fail_out === 1'b1) n_txf++;
      if (rx_done_out === 1'b1) n_rxd++;
      if (rx_fail_out === 1'b1) n_rxf++;
   end

   task automatic finish_test;
      $display("counts: %0d compares, %0d mismatches", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk_word(input logic [15:0] g, input logic [15:0] e, input string what);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, g, e);
      end
   endtask

   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input int idx);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("BAD %0t byte %0d got %h exp %h", $time, idx, g, e);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge ref_clk_in);
      #1 bm_req_in = '{1'b1, a, d};
      @(posedge ref_clk_in);
      #1 bm_req_in.wr = 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [15:0] d);
      @(posedge ref_clk_in);
      #1 bm_req_in.addr = a;
      @(posedge ref_clk_in);
      #1 d = bm_rdata_out;
   endtask

   // Waits for the whole expected stream, then a few idle cycles to catch extra bytes.
   task automatic check_frame;
      for (int i = 0; i < 3000 && serial_peer_model_i.got.size() < exp_q.size(); i++) @(posedge ref_clk_in);
      repeat (6) @(posedge ref_clk_in);
      chk_word(16'(serial_peer_model_i.got.size()), 16'(exp_q.size()), "frame length");
      foreach (exp_q[i]) chk_byte(serial_peer_model_i.got[i], exp_q[i], i);
      serial_peer_model_i.got.delete();
   endtask

   // Pulse counters start from zero before each run, since a pulse may come before the frame check.
   task automatic clear_counts;
      n_txd = 0;
      n_txf = 0;
      n_rxd = 0;
      n_rxf = 0;
   endtask

   task automatic tx_run;
      clear_counts();
      #1 send_req_in = 1'b1;
      check_frame();
      chk_word(16'(busy_out), 16'h0001, "busy while waiting");
      foreach (rep_q[i]) serial_peer_model_i.send(rep_q[i]);
      // The request drops before the next edge, or the idle engine would start a second send.
      for (int i = 0; i < 100 && tx_done_out !== 1'b1 && tx_fail_out !== 1'b1; i++) begin
         @(posedge ref_clk_in);
         #1;
      end
      send_req_in = 1'b0;
      @(posedge ref_clk_in);
      #1 chk_word(16'(busy_out), 16'h0000, "idle after reply");
   endtask

   task automatic rx_run;
      clear_counts();
      foreach (rep_q[i]) serial_peer_model_i.send(rep_q[i]);
      check_frame();
   endtask

   initial begin
      #200000;
      err_count++;
      finish_test();
   end

   initial begin
      err_count = 0; tests_run = 0; n_txd = 0; n_txf = 0; n_rxd = 0; n_rxf = 0;
      srst_in = 1'b1; send_req_in = 1'b0; sum_check_switch_in = 1'b1; bm_req_in = '0;
      repeat (10) @(posedge ref_clk_in);
      #1 srst_in = 1'b0;
      rd(`BMF_ADDR_UNIT, rv); chk_word(rv, 16'h0000, "unit reset");
      wr(`BMF_ADDR_UNIT, 16'h0001);
      rd(`BMF_ADDR_UNIT, rv); chk_word(rv, 16'h0001, "unit write");
      wr(`BMF_ADDR_TXRES, 16'h1234);
      rd(`BMF_ADDR_TXRES, rv); chk_word(rv, 16'h0000, "result read-only");
      rd(12'h0FF, rv); chk_word(rv, 16'h0000, "unmapped");
      $display("test registers done");
      // Odd byte count with boundary values, peer stalling.
      wr(`BMF_ADDR_TXCNT, 16'h0003); wr(`BMF_ADDR_TXDAT, 16'h0211); wr(`BMF_ADDR_TXDAT + 12'h001, 16'h00FF);
      serial_peer_model_i.slow = 1'b1;
      exp_q = '{8'h05, 8'h03, 8'h00, 8'h11, 8'h02, 8'hFF, 8'h15, 8'h01};
      rep_q = '{8'h06};
      tx_run();
      chk_word(16'(n_txd), 16'h0001, "ack done");
      serial_peer_model_i.slow = 1'b0;
      $display("test binary send done");
      wr(`BMF_ADDR_UNIT, 16'h0000); wr(`BMF_ADDR_TXESC, 16'h1002);
      wr(`BMF_ADDR_TXCNT, 16'h0001); wr(`BMF_ADDR_TXDAT, 16'h1002);
      exp_q = '{8'h05, 8'h01, 8'h00, 8'h10, 8'h02, 8'h10, 8'h10, 8'h13, 8'h00};
      rep_q = '{8'h15, 8'h22, 8'h00};
      tx_run();
      chk_word(16'(n_txf), 16'h0001, "nak fail");
      rd(`BMF_ADDR_TXRES, rv); chk_word(rv, 16'h0022, "peer code");
      wr(`BMF_ADDR_TXESC, 16'h0000);
      $display("test escaped send done");
      wr(`BMF_ADDR_ASCII, 16'h0001); wr(`BMF_ADDR_TXDAT, 16'h12AB);
      exp_q = '{8'h05, 8'h30, 8'h31, 8'h30, 8'h30, 8'h41, 8'h42, 8'h31, 8'h32, 8'hBE, 8'h00};
      rep_q = '{8'h06};
      tx_run();
      chk_word(16'(n_txd), 16'h0001, "ascii ack");
      wr(`BMF_ADDR_ASCII, 16'h0000);
      $display("test ascii send done");
      // Escaped transparent byte in the data, then a surplus byte with the sum off.
      wr(`BMF_ADDR_RXESC, 16'h1002);
      #1 sum_check_switch_in = 1'b0;
      exp_q = '{8'h06};
      rep_q = '{8'h05, 8'h01, 8'h00, 8'h10, 8'h02, 8'hBB, 8'hCC};
      rx_run();
      chk_word(16'(n_rxd), 16'h0001, "rx done");
      rd(`BMF_ADDR_RXCNT, rv); chk_word(rv, 16'h0001, "rx count");
      rd(`BMF_ADDR_RXDAT, rv); chk_word(rv, 16'hBB02, "rx data");
      rd(`BMF_ADDR_RXRES, rv); chk_word(rv, 16'h0000, "rx result ok");
      $display("test escaped receive done");
      wr(`BMF_ADDR_ASCII, 16'h0001);
      exp_q = '{8'h06};
      rep_q = '{8'h05, 8'h30, 8'h31, 8'h30, 8'h30, 8'h41, 8'h42, 8'h31, 8'h32};
      rx_run();
      chk_word(16'(n_rxd), 16'h0001, "ascii rx done");
      rd(`BMF_ADDR_RXCNT, rv); chk_word(rv, 16'h0001, "ascii rx count");
      rd(`BMF_ADDR_RXDAT, rv); chk_word(rv, 16'h12AB, "ascii rx data");
      wr(`BMF_ADDR_ASCII, 16'h0000);
      $display("test ascii receive done");
      #1 sum_check_switch_in = 1'b1;
      exp_q = '{8'h15, 8'h03, 8'h71};
      rep_q = '{8'h05, 8'h01, 8'h00, 8'hAA, 8'hBB, 8'h00, 8'h00};
      rx_run();
      chk_word(16'(n_rxf), 16'h0001, "rx fail");
      rd(`BMF_ADDR_RXRES, rv); chk_word(rv, `BMF_ERR_SUM, "rx result code");
      $display("test bad sum receive done");
      finish_test();
   end
endmodule // tb_bidir_message_framer
